//--- common/card_status_map.vh
`ifndef CARD_STATUS_MAP_VH
`define CARD_STATUS_MAP_VH

// Width of the card status word
`define CSW_WIDTH 32
// Bit positions of the individual flags
`define CSW_BIT_RANGE 31
`define CSW_BIT_MISALIGN 30
`define CSW_BIT_BLK_SIZE 29
`define CSW_BIT_ERASE_ORDER 28
`define CSW_BIT_ERASE_SELECT 27
`define CSW_BIT_PROTECT 26
`define CSW_BIT_LOCKED 25
`define CSW_BIT_LOCK_OP 24
`define CSW_BIT_CMD_CRC 23
`define CSW_BIT_BAD_CMD 22
`define CSW_BIT_ECC_FAIL 21
`define CSW_BIT_CTRL_FAULT 20
`define CSW_BIT_GENERAL 19
`define CSW_BIT_UNDERRUN 18
`define CSW_BIT_OVERRUN 17
`define CSW_BIT_IDENT_REWRITE 16
`define CSW_BIT_PARTIAL_ERASE 15
`define CSW_BIT_ECC_BYPASS 14
`define CSW_BIT_ERASE_ABORT 13
`define CSW_STATE_MSB 12
`define CSW_STATE_LSB 9
`define CSW_BIT_BUF_EMPTY 8
`define CSW_BIT_VENDOR_EXT 5
`define CSW_AUX_MSB 3
`define CSW_AUX_LSB 0
// Clear classes: B clears one valid command later, C clears on read
`define CSW_CLASS_B_MASK 32'h00C00000
`define CSW_CLASS_C_MASK 32'hFD3FA020
// Reserved bits that always read zero
`define CSW_RSVD_HI_MSB 7
`define CSW_RSVD_HI_LSB 6
`define CSW_RSVD_MID 4
// Reset value of the status word and of the sticky flags
`define CSW_RESET 32'h00000000
// Card state codes, 9 to 15 reserved
`define CSW_ST_IDLE 4'h0
`define CSW_ST_READY 4'h1
`define CSW_ST_IDENT 4'h2
`define CSW_ST_STBY 4'h3
`define CSW_ST_TRAN 4'h4
`define CSW_ST_DATA 4'h5
`define CSW_ST_RCV 4'h6
`define CSW_ST_PRG 4'h7
`define CSW_ST_DIS 4'h8
// Serialiser bit count, MSB first
`define CSW_SHIFT_COUNT 6'h20
`define CSW_COUNT_ONE 6'h01
`define CSW_COUNT_ZERO 6'h00

`endif

//--- logic/card_status_word_logic.v
// Overview of operation
// - Argument out of permitted range sets bit 31; cleared by a read.
// - Address not aligned to block length sets bit 30, also during execution.
// - Bad block length or byte count mismatch sets bit 29.
// - Erase commands in invalid order set bit 28.
// - Invalid erase selection found during execution sets bit 27.
// - Write to a protected block sets bit 26.
// - Bit 25 follows the actual lock state, never clears on read.
// - Lock/unlock sequence or password error, or locked access, sets bit 24.
// - Failed command checksum sets bit 23; later valid commands clear it.
// - Command illegal in the present state sets bit 22.
// - Error correction applied but failed sets bit 21.
// - Internal controller fault sets bit 20; general error sets bit 19.
// - Stream read underrun sets bit 18; stream write overrun sets bit 17.
// - Identification rewrite, read-only mismatch or protect-bit reversal sets bit 16.
// - Erase skipped protected blocks, only partial: sets bit 15.
// - Command without error correction sets bit 14; follows card state.
// - Pending erase discarded by an out-of-sequence command sets bit 13.
// - Bits 12 to 9 carry the card state code, 0 to 8.
// - Bit 8 mirrors the receive-buffer-empty condition, 1 meaning empty.
// - Bit 5 set when an application command is expected or interpreted.
// - The 32-bit word goes out inside the response, MSB first.
// - Class B clears one valid command later, C on read, A follows state.
`timescale 1ns/1ps
`default_nettype none
`include "card_status_map.vh"

module card_status_word_logic (
    input wire clk_i,
    input wire rst_i,
    // Host bus clock, sampled here and edge-detected
    input wire link_clk_i,
    // One-cycle error and status events from the card controller
    input wire range_evt_i,
    input wire misalign_evt_i,
    input wire blk_size_evt_i,
    input wire erase_order_evt_i,
    input wire erase_select_evt_i,
    input wire protect_evt_i,
    input wire lock_op_evt_i,
    input wire crc_fail_evt_i,
    input wire bad_cmd_evt_i,
    input wire ecc_fail_evt_i,
    input wire ctrl_fault_evt_i,
    input wire general_fault_evt_i,
    input wire underrun_evt_i,
    input wire overrun_evt_i,
    input wire ident_rewrite_evt_i,
    input wire ro_section_mismatch_evt_i,
    input wire protect_bit_reverse_evt_i,
    input wire partial_erase_evt_i,
    input wire erase_abort_evt_i,
    input wire vendor_ext_cmd_evt_i,
    // Card-state levels
    input wire locked_indicator_i,
    input wire ecc_bypass_i,
    input wire [3:0] card_state_i,
    input wire rx_buf_empty_i,
    input wire [3:0] aux_bits_i,
    // Command framing events
    input wire cmd_valid_i,
    input wire status_read_i,
    // Outputs
    output reg [31:0] status_o,
    output reg resp_bit_o,
    output reg resp_active_o,
    output reg resp_done_o
);

    // Sticky class B and C flags
    reg [31:0] sticky_q;
    reg [31:0] sticky_d;
    // Class B flags already reported in a response
    reg [31:0] b_seen_q;
    reg [31:0] b_seen_d;
    // Event vector lined up with the status bits
    reg [31:0] set_w;
    // Clear vectors, per class and combined
    reg [31:0] clr_b_w;
    reg [31:0] clr_c_w;
    wire [31:0] clr_w;
    // Per-class views of the sticky storage
    wire [31:0] class_b_w;
    wire [31:0] class_c_w;
    // Composed status word
    reg [31:0] status_w;
    // Serialiser states; the shift state is the frame in flight
    localparam [1:0] SER_IDLE = 2'b00;
    localparam [1:0] SER_SHIFT = 2'b01;
    // Serialiser state, shifter and next values
    reg [1:0] ser_state_q;
    reg [1:0] ser_state_d;
    reg [31:0] shift_q;
    reg [31:0] shift_d;
    reg [5:0] count_q;
    reg [5:0] count_d;
    reg resp_bit_d;
    reg resp_active_d;
    reg resp_done_d;
    // Host clock edge detection
    reg link_prev_q;
    wire link_sync;
    wire link_rise;
    wire load_go;

    // Host clock arrives from outside the domain
    level_sync #(
        .WIDTH(1)
    ) u_link_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(link_clk_i),
        .sync_o(link_sync)
    );

    // Rising edge of the sampled host clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            link_prev_q <= 1'b0;
        end else begin
            link_prev_q <= link_sync;
        end
    end

    // Idle level is low on both sides, so no false edge after reset
    assign link_rise = link_sync & ~link_prev_q;

    // A read that arrives mid-shift is refused, so it must not clear flags
    assign load_go = status_read_i & ~resp_active_o;

    // Map each event onto its flag position
    always @* begin
        set_w = `CSW_RESET;
        // Argument, address and length faults
        set_w[`CSW_BIT_RANGE] = range_evt_i;
        set_w[`CSW_BIT_MISALIGN] = misalign_evt_i;
        set_w[`CSW_BIT_BLK_SIZE] = blk_size_evt_i;
        // Erase, protection and lock faults
        set_w[`CSW_BIT_ERASE_ORDER] = erase_order_evt_i;
        set_w[`CSW_BIT_ERASE_SELECT] = erase_select_evt_i;
        set_w[`CSW_BIT_PROTECT] = protect_evt_i;
        set_w[`CSW_BIT_LOCK_OP] = lock_op_evt_i;
        // Command faults, cleared one command later
        set_w[`CSW_BIT_CMD_CRC] = crc_fail_evt_i;
        set_w[`CSW_BIT_BAD_CMD] = bad_cmd_evt_i;
        // Controller and transfer faults
        set_w[`CSW_BIT_ECC_FAIL] = ecc_fail_evt_i;
        set_w[`CSW_BIT_CTRL_FAULT] = ctrl_fault_evt_i;
        set_w[`CSW_BIT_GENERAL] = general_fault_evt_i;
        set_w[`CSW_BIT_UNDERRUN] = underrun_evt_i;
        set_w[`CSW_BIT_OVERRUN] = overrun_evt_i;
        // Three distinct causes share one flag
        set_w[`CSW_BIT_IDENT_REWRITE] = ident_rewrite_evt_i | ro_section_mismatch_evt_i
            | protect_bit_reverse_evt_i;
        // Erase and command status events
        set_w[`CSW_BIT_PARTIAL_ERASE] = partial_erase_evt_i;
        set_w[`CSW_BIT_ERASE_ABORT] = erase_abort_evt_i;
        set_w[`CSW_BIT_VENDOR_EXT] = vendor_ext_cmd_evt_i;
    end

    // Class C clears on an accepted read only
    always @* begin
        clr_c_w = `CSW_RESET;
        if (load_go) begin
            clr_c_w = `CSW_CLASS_C_MASK;
        end
    end

    // Class B clears on a valid command once the flag has been reported
    always @* begin
        clr_b_w = `CSW_RESET;
        if (cmd_valid_i) begin
            clr_b_w = b_seen_q;
        end
    end

    // Either class may clear in the same cycle
    assign clr_w = clr_b_w | clr_c_w;

    // Set wins over clear in the same cycle
    always @* begin
        sticky_d = ((sticky_q & ~clr_w) | set_w) & (`CSW_CLASS_B_MASK | `CSW_CLASS_C_MASK);
    end

    // Per-class views of the stored flags
    assign class_b_w = sticky_q & `CSW_CLASS_B_MASK;
    assign class_c_w = sticky_q & `CSW_CLASS_C_MASK;

    // Class B flags are marked once they have gone out in a response
    always @* begin
        b_seen_d = b_seen_q;
        if (cmd_valid_i) begin
            b_seen_d = `CSW_RESET;
        end
        if (load_go) begin
            b_seen_d = b_seen_d | class_b_w;
        end
        // A fresh set must survive its own first report cycle
        b_seen_d = b_seen_d & ~set_w;
    end

    // Sticky flag storage
    always @(posedge clk_i) begin
        if (rst_i) begin
            sticky_q <= `CSW_RESET;
            b_seen_q <= `CSW_RESET;
        end else begin
            sticky_q <= sticky_d;
            b_seen_q <= b_seen_d;
        end
    end

    // Compose the word; class A fields follow live card state
    always @* begin
        status_w = class_b_w | class_c_w;
        status_w[`CSW_BIT_LOCKED] = locked_indicator_i;
        status_w[`CSW_BIT_ECC_BYPASS] = ecc_bypass_i;
        status_w[`CSW_STATE_MSB:`CSW_STATE_LSB] = card_state_i;
        status_w[`CSW_BIT_BUF_EMPTY] = rx_buf_empty_i;
        // Reserved bits held low whatever the storage holds
        status_w[`CSW_RSVD_HI_MSB:`CSW_RSVD_HI_LSB] = 2'h0;
        status_w[`CSW_RSVD_MID] = 1'b0;
        // Application and test bits pass through, tied low when unused
        status_w[`CSW_AUX_MSB:`CSW_AUX_LSB] = aux_bits_i;
    end

    // Registered copy for local inspection
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= `CSW_RESET;
        end else begin
            status_o <= status_w;
        end
    end

    // Serialise the snapshot MSB first, one bit per host clock rise
    always @* begin
        ser_state_d = ser_state_q;
        shift_d = shift_q;
        count_d = count_q;
        resp_bit_d = resp_bit_o;
        resp_active_d = resp_active_o;
        resp_done_d = 1'b0;
        case (ser_state_q)
            SER_IDLE: begin
                if (load_go) begin
                    // Snapshot taken before this edge's class C clear lands
                    shift_d = status_w;
                    count_d = `CSW_SHIFT_COUNT;
                    resp_bit_d = status_w[`CSW_WIDTH-1];
                    resp_active_d = 1'b1;
                    ser_state_d = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                // Each bit holds until the next sampled host clock rise
                if (link_rise) begin
                    shift_d = {shift_q[`CSW_WIDTH-2:0], 1'b0};
                    count_d = count_q - `CSW_COUNT_ONE;
                    resp_bit_d = shift_q[`CSW_WIDTH-2];
                    if (count_q == `CSW_COUNT_ONE) begin
                        // Last bit has had its full host clock period
                        resp_active_d = 1'b0;
                        resp_done_d = 1'b1;
                        resp_bit_d = 1'b0;
                        ser_state_d = SER_IDLE;
                    end
                end
            end
            default: begin
                // Unused code: back to idle with the line low
                count_d = `CSW_COUNT_ZERO;
                resp_active_d = 1'b0;
                resp_bit_d = 1'b0;
                ser_state_d = SER_IDLE;
            end
        endcase
    end

    // Serialiser registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ser_state_q <= SER_IDLE;
            shift_q <= `CSW_RESET;
            count_q <= `CSW_COUNT_ZERO;
            resp_bit_o <= 1'b0;
            resp_active_o <= 1'b0;
            resp_done_o <= 1'b0;
        end else begin
            ser_state_q <= ser_state_d;
            shift_q <= shift_d;
            count_q <= count_d;
            resp_bit_o <= resp_bit_d;
            resp_active_o <= resp_active_d;
            resp_done_o <= resp_done_d;
        end
    end

    // Execution-time flags wait in sticky storage for the next poll

endmodule // card_status_word_logic

`default_nettype wire

//--- logic/level_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for levels from a foreign domain
module level_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // level_sync

`default_nettype wire

//--- tb/card_status_word_logic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module csw_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic range_evt_i,
    input wire logic crc_fail_evt_i,
    input wire logic ident_rewrite_evt_i,
    input wire logic ro_section_mismatch_evt_i,
    input wire logic protect_bit_reverse_evt_i,
    input wire logic locked_indicator_i,
    input wire logic ecc_bypass_i,
    input wire logic [3:0] card_state_i,
    input wire logic rx_buf_empty_i,
    input wire logic [3:0] aux_bits_i,
    input wire logic status_read_i,
    input wire logic [31:0] status_o,
    input wire logic resp_bit_o,
    input wire logic resp_active_o,
    input wire logic resp_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Level fields lag their inputs by one register
    a_levels_follow: assert property (1'b1 |=>
        status_o[25] == $past(locked_indicator_i) && status_o[14] == $past(ecc_bypass_i)
        && status_o[12:9] == $past(card_state_i) && status_o[8] == $past(rx_buf_empty_i)
        && status_o[3:0] == $past(aux_bits_i)) else $error("level field mismatch");
    a_reserved_zero: assert property (status_o[7:6] == 2'h0 && !status_o[4])
        else $error("reserved bits set");
    // Sticky flag then word register
    a_range_sets: assert property (range_evt_i |-> ##2 status_o[31])
        else $error("range flag missing");
    a_crc_sets: assert property (crc_fail_evt_i |-> ##2 status_o[23])
        else $error("crc flag missing");
    a_ident_sets: assert property ((ident_rewrite_evt_i || ro_section_mismatch_evt_i
        || protect_bit_reverse_evt_i) |-> ##2 status_o[16]) else $error("ident flag missing");
    a_read_starts: assert property (status_read_i && !resp_active_o |=> resp_active_o)
        else $error("read not taken");
    a_done_single: assert property (resp_done_o |=> !resp_done_o)
        else $error("done too long");
    a_done_ends: assert property ($fell(resp_active_o) |-> resp_done_o)
        else $error("frame end without done");
    a_idle_low: assert property (!resp_active_o |-> !resp_bit_o)
        else $error("bit high while idle");
    c_crc: cover property (crc_fail_evt_i);
    c_frame: cover property ($fell(resp_active_o));
    c_refused: cover property (status_read_i && resp_active_o);
endmodule // csw_asserts
bind card_status_word_logic csw_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .range_evt_i(range_evt_i), .crc_fail_evt_i(crc_fail_evt_i),
    .ident_rewrite_evt_i(ident_rewrite_evt_i),
    .ro_section_mismatch_evt_i(ro_section_mismatch_evt_i),
    .protect_bit_reverse_evt_i(protect_bit_reverse_evt_i),
    .locked_indicator_i(locked_indicator_i), .ecc_bypass_i(ecc_bypass_i),
    .card_state_i(card_state_i), .rx_buf_empty_i(rx_buf_empty_i), .aux_bits_i(aux_bits_i),
    .status_read_i(status_read_i), .status_o(status_o), .resp_bit_o(resp_bit_o),
    .resp_active_o(resp_active_o), .resp_done_o(resp_done_o));
`default_nettype wire

//--- tb/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    input wire logic resp_bit_i,
    input wire logic resp_active_i,
    output logic link_clk_o,
    output logic [31:0] word_o
);
    // Host clock runs only inside a frame, so idle edges cannot shift bits
    initial begin
        link_clk_o = 1'b0;
        word_o = 32'h00000000;
        forever begin
            @(posedge resp_active_i);
            // Keep host clock edges off the system clock edges
            #10;
            while (resp_active_i === 1'b1) begin
                #160 link_clk_o = 1'b1;
                word_o = {word_o[30:0], resp_bit_i};
                #160 link_clk_o = 1'b0;
            end
        end
    end
endmodule // host_link_model
`default_nettype wire

//--- tb/tb_card_status_word_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_card_status_word_logic;
    logic clk_i, rst_i, link, lk, eb, rx, cv, sr;
    logic [19:0] ev;
    logic [3:0] st, aux;
    logic [31:0] status_o, word, b;
    logic resp_bit_o, resp_active_o, resp_done_o;
    logic [31:0] q[$];
    int n_fail, cmp_count, cyc, seed;
    int pos[20] = '{31, 30, 29, 28, 27, 26, 24, 23, 22, 21, 20, 19, 18, 17, 16, 16, 16, 15, 13, 5};
    card_status_word_logic dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link),
        .range_evt_i(ev[0]), .misalign_evt_i(ev[1]), .blk_size_evt_i(ev[2]),
        .erase_order_evt_i(ev[3]), .erase_select_evt_i(ev[4]), .protect_evt_i(ev[5]),
        .lock_op_evt_i(ev[6]), .crc_fail_evt_i(ev[7]), .bad_cmd_evt_i(ev[8]),
        .ecc_fail_evt_i(ev[9]), .ctrl_fault_evt_i(ev[10]), .general_fault_evt_i(ev[11]),
        .underrun_evt_i(ev[12]), .overrun_evt_i(ev[13]), .ident_rewrite_evt_i(ev[14]),
        .ro_section_mismatch_evt_i(ev[15]), .protect_bit_reverse_evt_i(ev[16]),
        .partial_erase_evt_i(ev[17]), .erase_abort_evt_i(ev[18]), .vendor_ext_cmd_evt_i(ev[19]),
        .locked_indicator_i(lk), .ecc_bypass_i(eb), .card_state_i(st), .rx_buf_empty_i(rx),
        .aux_bits_i(aux), .cmd_valid_i(cv), .status_read_i(sr), .status_o(status_o),
        .resp_bit_o(resp_bit_o), .resp_active_o(resp_active_o), .resp_done_o(resp_done_o));
    host_link_model host (.resp_bit_i(resp_bit_o), .resp_active_i(resp_active_o),
        .link_clk_o(link), .word_o(word));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    // Expected word from the level inputs alone
    function automatic logic [31:0] lv();
        lv = {6'h00, lk, 10'h000, eb, 1'b0, st, rx, 4'h0, aux};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Status poll; a second request mid-frame must be ignored
    task automatic rd(input logic [31:0] e);
        int n;
        q.push_back(e);
        sr = 1'b1;
        tick();
        sr = 1'b0;
        tick();
        sr = 1'b1;
        tick();
        sr = 1'b0;
        for (n = 0; n < 400 && resp_active_o !== 1'b0; n++) tick();
        if (resp_active_o !== 1'b0) n_fail++;
        tick();
    endtask
    task automatic finish_test();
        if (q.size() != 0) n_fail++;
        $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Each finished frame is matched against the oldest note
    always @(posedge clk_i) begin
        if (resp_done_o === 1'b1) begin
            if (q.size() == 0) n_fail++;
            else check(word, q.pop_front());
        end
    end
    // Hang guard, frames take about 260 cycles each
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        {rst_i, lk, eb, rx, cv, sr, ev, st, aux} = '0;
        rst_i = 1'b1;
        seed = $urandom(32'h90AB);
        repeat (5) tick();
        rst_i = 1'b0;
        tick();
        for (int i = 0; i < 20; i++) begin
            {lk, eb, rx, aux} = 7'($urandom);
            st = 4'($urandom_range(8, 0));
            ev[i] = 1'b1;
            tick();
            ev = '0;
            repeat (3) tick();
            b = 32'h00000001 << pos[i];
            rd(lv() | b);
            rd(lv() | ((pos[i] == 23 || pos[i] == 22) ? b : 32'h0));
            cv = 1'b1;
            tick();
            cv = 1'b0;
            repeat (3) tick();
            rd(lv());
        end
        finish_test();
    end
endmodule // tb_card_status_word_logic
`default_nettype wire
